// *** shrb_holding_bank.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Every holding register is a read/write 16-bit word unless restricted.
// - Holding reads are served through function codes 0x03 and 0x17.
// - Writes are accepted through codes 0x06 and 0x10.
// - Code 0x17 writes and reads holding registers in one transaction.
// - Broadcast holding reads are ignored.
// - Any unicast access to an unmapped address gets an exception answer.
// - Non-volatile settings survive loss and return of the supply input.
// - Link-defaults register restores link settings; broadcast writes only.
// - Chain-assignment register starts daisy-chain addressing; broadcast writes only.
// - Factory reset restores all settings except link settings.
// - Log pointer reset returns the alarm-log read pointer to start.
// - Word zero switches the power output on or off.
// - Restore-select decides whether on/off state survives a supply cycle.
// - Words 700-702 hold server address, baud rate and parity/stop.
// - Word 703 holds the reply delay.
// - Voltage target source picks knob, analog terminal or link target.
// - Current target source picks analog terminal or link target.
// - Overvoltage policy picks hiccup or latched shutdown.
// - Overcurrent policy picks hiccup, latched shutdown or limiting.
// - Manual terminal control drives shortage terminals open or shorted.
// - Two fifteen-word scratch areas store and return host data.
// - Server address, baud rate and parity/stop changes take effect only after the restart request; reply delay applies at once.
module shrb_holding_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Supply input has returned after an interruption
  input wire logic supply_restore,
  // Word request from the protocol engine
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_bcast,
  input wire logic req_rd,
  // Word answer
  output logic rsp_valid,
  output logic rsp_exc,
  output logic [15:0] rsp_data,
  // Settings towards the supply
  output logic output_on,
  output logic [15:0] voltage_target_source,
  output logic [15:0] current_target_source,
  output logic [15:0] link_voltage_target,
  output logic [15:0] link_current_target,
  output logic [15:0] overvoltage_policy,
  output logic [15:0] overcurrent_policy,
  output logic [15:0] reply_delay,
  // Shortage terminals under manual control
  output logic voltage_shortage_signal_manual,
  output logic voltage_shortage_signal_short,
  output logic current_shortage_signal_manual,
  output logic current_shortage_signal_short,
  // Link settings in force
  output logic [15:0] active_server_address,
  output logic [15:0] active_baud_rate,
  output logic [15:0] active_parity_stop,
  // One-cycle action pulses
  output logic chain_assign_start,
  output logic log_pointer_reset
);

  logic [15:0] hold [0:65];
  logic [7:0] hit;
  logic [6:0] slot;
  logic is_rd;
  logic is_wr;
  logic is_diag;
  logic restricted_wo;
  logic [7:0] exc;
  logic do_write;
  logic do_restart;

  function automatic logic [7:0] find_slot(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < shrb_pkg::NUM_SINGLE; i++) begin
      if (a == shrb_pkg::SINGLE_ADDR[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    // Scratch words sit back to back from each base.
    if (a >= shrb_pkg::ADDR_SCRATCH_AREA_1 && a < shrb_pkg::ADDR_SCRATCH_AREA_1 + shrb_pkg::SCRATCH_WORDS) begin
      r = {1'b1, 7'(a - shrb_pkg::ADDR_SCRATCH_AREA_1) + shrb_pkg::SLOT_SCRATCH_AREA_1};
    end
    if (a >= shrb_pkg::ADDR_SCRATCH_AREA_2 && a < shrb_pkg::ADDR_SCRATCH_AREA_2 + shrb_pkg::SCRATCH_WORDS) begin
      r = {1'b1, 7'(a - shrb_pkg::ADDR_SCRATCH_AREA_2) + shrb_pkg::SLOT_SCRATCH_AREA_2};
    end
    return r;
  endfunction

  function automatic logic is_link_slot(input int s);
    return s == int'(shrb_pkg::SLOT_LINK_SERVER_ADDRESS) || s == int'(shrb_pkg::SLOT_LINK_BAUD_RATE) ||
      s == int'(shrb_pkg::SLOT_LINK_PARITY_STOP) || s == int'(shrb_pkg::SLOT_REPLY_DELAY);
  endfunction

  function automatic logic [15:0] factory_value(input int s);
    logic [15:0] v;
    v = shrb_pkg::RST_SETTING;
    if (s == int'(shrb_pkg::SLOT_LINK_SERVER_ADDRESS)) begin
      v = shrb_pkg::RST_LINK_SERVER_ADDRESS;
    end
    if (s == int'(shrb_pkg::SLOT_LINK_BAUD_RATE)) begin
      v = shrb_pkg::RST_LINK_BAUD_RATE;
    end
    if (s == int'(shrb_pkg::SLOT_LINK_PARITY_STOP)) begin
      v = shrb_pkg::RST_LINK_PARITY_STOP;
    end
    if (s == int'(shrb_pkg::SLOT_REPLY_DELAY)) begin
      v = shrb_pkg::RST_REPLY_DELAY;
    end
    return v;
  endfunction

  assign hit = find_slot(req_addr);
  assign slot = hit[6:0];

  always_comb begin
    is_rd = req_func == shrb_pkg::FC_READ_HOLD || (req_func == shrb_pkg::FC_READ_WRITE && req_rd);
    is_wr = req_func == shrb_pkg::FC_WRITE_SINGLE || req_func == shrb_pkg::FC_WRITE_MULTI ||
      (req_func == shrb_pkg::FC_READ_WRITE && !req_rd);
    is_diag = req_func == shrb_pkg::FC_DIAG;
    restricted_wo = slot == shrb_pkg::SLOT_LINK_DEFAULTS_FORCE || slot == shrb_pkg::SLOT_CHAIN_ADDRESS_ASSIGN;
    exc = shrb_pkg::EXC_NONE;
    if (!(is_rd || is_wr || is_diag)) begin
      exc = shrb_pkg::EXC_FUNC;
    end else if (is_diag) begin
      if (req_addr != shrb_pkg::SUB_RESTART) begin
        exc = shrb_pkg::EXC_FUNC;
      end else if (req_wdata != shrb_pkg::DIAG_DATA_ZERO && req_wdata != shrb_pkg::DIAG_DATA_ONES) begin
        exc = shrb_pkg::EXC_DATA;
      end
    end else if (!hit[7]) begin
      exc = shrb_pkg::EXC_ADDR;
    end else if (restricted_wo && (is_rd || !req_bcast)) begin
      // These two words cannot be read and take broadcast writes only.
      exc = shrb_pkg::EXC_ADDR;
    end
  end

  // A broadcast read is dropped before it can touch anything.
  assign do_write = req_valid && is_wr && exc == shrb_pkg::EXC_NONE;
  assign do_restart = req_valid && is_diag && exc == shrb_pkg::EXC_NONE && !req_bcast;

  // Register storage, factory defaults and supply-cycle retention.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < shrb_pkg::NUM_SLOTS; i++) begin
        hold[i] <= factory_value(i);
      end
    end else begin
      // Settings are held as non-volatile; only the on/off word is volatile by choice.
      if (supply_restore && !hold[shrb_pkg::SLOT_ON_OFF_RESTORE_SELECT][shrb_pkg::RESTORE_BIT]) begin
        hold[shrb_pkg::SLOT_OUTPUT_ON_OFF] <= shrb_pkg::RST_SETTING;
      end
      if (do_write) begin
        if (slot == shrb_pkg::SLOT_LINK_DEFAULTS_FORCE) begin
          for (int i = 0; i < shrb_pkg::NUM_SLOTS; i++) begin
            if (is_link_slot(i)) begin
              hold[i] <= factory_value(i);
            end
          end
        end else if (slot == shrb_pkg::SLOT_SETTINGS_DEFAULT_RESTORE) begin
          for (int i = 0; i < shrb_pkg::NUM_SLOTS; i++) begin
            if (!is_link_slot(i)) begin
              hold[i] <= factory_value(i);
            end
          end
        end else if (slot != shrb_pkg::SLOT_CHAIN_ADDRESS_ASSIGN) begin
          hold[slot] <= req_wdata;
        end
      end
    end
  end

  // Answer path: broadcasts never get an answer.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_exc <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= req_valid && !req_bcast;
      rsp_exc <= exc != shrb_pkg::EXC_NONE;
      if (exc != shrb_pkg::EXC_NONE) begin
        rsp_data <= {8'h00, exc};
      end else if (is_rd) begin
        rsp_data <= hold[slot];
      end else begin
        rsp_data <= req_wdata;
      end
    end
  end

  // Changed server address, baud rate and parity/stop only go live on a restart request.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      active_server_address <= shrb_pkg::RST_LINK_SERVER_ADDRESS;
      active_baud_rate <= shrb_pkg::RST_LINK_BAUD_RATE;
      active_parity_stop <= shrb_pkg::RST_LINK_PARITY_STOP;
    end else if (do_restart) begin
      active_server_address <= hold[shrb_pkg::SLOT_LINK_SERVER_ADDRESS];
      active_baud_rate <= hold[shrb_pkg::SLOT_LINK_BAUD_RATE];
      active_parity_stop <= hold[shrb_pkg::SLOT_LINK_PARITY_STOP];
    end
  end

  // One-cycle action pulses.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chain_assign_start <= 1'b0;
      log_pointer_reset <= 1'b0;
    end else begin
      chain_assign_start <= do_write && slot == shrb_pkg::SLOT_CHAIN_ADDRESS_ASSIGN;
      log_pointer_reset <= do_write && slot == shrb_pkg::SLOT_LOG_POINTER_RESET;
    end
  end

  // Manual drive of the shortage terminals.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      voltage_shortage_signal_manual <= 1'b0;
      voltage_shortage_signal_short <= 1'b0;
      current_shortage_signal_manual <= 1'b0;
      current_shortage_signal_short <= 1'b0;
    end else begin
      voltage_shortage_signal_manual <= hold[shrb_pkg::SLOT_VSHORT_TERMINAL_FUNCTION] == shrb_pkg::TERM_FN_MANUAL;
      current_shortage_signal_manual <= hold[shrb_pkg::SLOT_ISHORT_TERMINAL_FUNCTION] == shrb_pkg::TERM_FN_MANUAL;
      voltage_shortage_signal_short <= hold[shrb_pkg::SLOT_VSHORT_TERMINAL_FUNCTION] == shrb_pkg::TERM_FN_MANUAL &&
        hold[shrb_pkg::SLOT_TERMINAL_OUTPUT_CONTROL_2][shrb_pkg::TOC_VSHORT_BIT];
      current_shortage_signal_short <= hold[shrb_pkg::SLOT_ISHORT_TERMINAL_FUNCTION] == shrb_pkg::TERM_FN_MANUAL &&
        hold[shrb_pkg::SLOT_TERMINAL_OUTPUT_CONTROL_2][shrb_pkg::TOC_ISHORT_BIT];
    end
  end

  assign output_on = hold[shrb_pkg::SLOT_OUTPUT_ON_OFF][shrb_pkg::ON_BIT];
  assign voltage_target_source = hold[shrb_pkg::SLOT_VOLTAGE_TARGET_SOURCE];
  assign current_target_source = hold[shrb_pkg::SLOT_CURRENT_TARGET_SOURCE];
  assign link_voltage_target = hold[shrb_pkg::SLOT_LINK_VOLTAGE_TARGET];
  assign link_current_target = hold[shrb_pkg::SLOT_LINK_CURRENT_TARGET];
  assign overvoltage_policy = hold[shrb_pkg::SLOT_OVERVOLTAGE_POLICY];
  assign overcurrent_policy = hold[shrb_pkg::SLOT_OVERCURRENT_POLICY];
  assign reply_delay = hold[shrb_pkg::SLOT_REPLY_DELAY];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_bcast_read_silent;
    req_valid && req_bcast && is_rd |=> !rsp_valid;
  endproperty
  a_bcast_read_silent: assert property (p_bcast_read_silent) else $error("broadcast read answered");

  property p_unmapped;
    req_valid && !req_bcast && (is_rd || is_wr) && !hit[7] |=> rsp_valid && rsp_exc && rsp_data == 16'h0002;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_bad_func;
    req_valid && !req_bcast && req_func == 8'h04 |=> rsp_exc && rsp_data == 16'h0001;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("foreign function code not refused");

  property p_write_read_back;
    logic [15:0] d;
    (do_write && slot == shrb_pkg::SLOT_LINK_VOLTAGE_TARGET, d = req_wdata) |=> link_voltage_target == d;
  endproperty
  a_write_read_back: assert property (p_write_read_back) else $error("written word not stored");

  property p_defaults_bcast_only;
    req_valid && !req_bcast && is_wr && req_addr == 16'h02D0 |=> rsp_exc ##0 $stable(reply_delay);
  endproperty
  a_defaults_bcast_only: assert property (p_defaults_bcast_only) else $error("unicast defaults write taken");

  property p_defaults_apply;
    do_write && slot == shrb_pkg::SLOT_LINK_DEFAULTS_FORCE |=> hold[shrb_pkg::SLOT_LINK_SERVER_ADDRESS] == 16'h0001;
  endproperty
  a_defaults_apply: assert property (p_defaults_apply) else $error("link defaults not restored");

  property p_factory_keeps_link;
    do_write && slot == shrb_pkg::SLOT_SETTINGS_DEFAULT_RESTORE |=>
      $stable(hold[shrb_pkg::SLOT_LINK_SERVER_ADDRESS]) && link_voltage_target == 16'h0000;
  endproperty
  a_factory_keeps_link: assert property (p_factory_keeps_link) else $error("factory reset wrong");

  property p_log_pulse;
    do_write && slot == shrb_pkg::SLOT_LOG_POINTER_RESET |=> log_pointer_reset ##1
      (!log_pointer_reset || $past(do_write && slot == shrb_pkg::SLOT_LOG_POINTER_RESET));
  endproperty
  a_log_pulse: assert property (p_log_pulse) else $error("log pointer reset pulse missing");

  // A write that lands with a supply return in the same cycle must still win.
  property p_on_write;
    do_write && slot == shrb_pkg::SLOT_OUTPUT_ON_OFF |=>
      output_on == $past(req_wdata[shrb_pkg::ON_BIT]);
  endproperty
  a_on_write: assert property (p_on_write) else $error("on/off word not applied");

  property p_chain_pulse;
    req_valid && req_bcast && is_wr && req_addr == shrb_pkg::ADDR_CHAIN_ADDRESS_ASSIGN |=>
      chain_assign_start && !rsp_valid;
  endproperty
  a_chain_pulse: assert property (p_chain_pulse) else $error("broadcast chain assignment ignored");

  property p_chain_bcast;
    chain_assign_start |-> $past(req_bcast) && $past(req_valid);
  endproperty
  a_chain_bcast: assert property (p_chain_bcast) else $error("chain assignment without broadcast");

  property p_restart_only;
    !do_restart |=> $stable(active_server_address) && $stable(active_baud_rate);
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("link settings changed without restart");

  // The restart copies the stored words, not whatever the host sends with it.
  property p_restart_apply;
    do_restart |=>
      active_server_address == $past(hold[shrb_pkg::SLOT_LINK_SERVER_ADDRESS]) &&
      active_parity_stop == $past(hold[shrb_pkg::SLOT_LINK_PARITY_STOP]);
  endproperty
  a_restart_apply: assert property (p_restart_apply) else $error("restart did not apply stored link settings");

  property p_restore_off;
    supply_restore && !hold[shrb_pkg::SLOT_ON_OFF_RESTORE_SELECT][0] && !do_write |=> !output_on;
  endproperty
  a_restore_off: assert property (p_restore_off) else $error("on/off kept without restore select");

endmodule

// *** shrb_pkg.sv ***
package shrb_pkg;

  // Function codes of the serial request/response protocol.
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_READ_WRITE = 8'h17;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [15:0] SUB_RESTART = 16'h0001;
  localparam logic [15:0] DIAG_DATA_ZERO = 16'h0000;
  localparam logic [15:0] DIAG_DATA_ONES = 16'hFF00;

  // Exception codes carried in the low byte of the answer.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;

  // Word addresses of the single-word holding registers, then the scratch-area bases and their length in words.
  localparam logic [15:0] ADDR_OUTPUT_ON_OFF = 16'h0000;
  localparam logic [15:0] ADDR_ON_OFF_SOURCE_SELECT = 16'h000A;
  localparam logic [15:0] ADDR_ON_OFF_RESTORE_SELECT = 16'h000B;
  localparam logic [15:0] ADDR_DEBOUNCE_STRENGTH = 16'h000C;
  localparam logic [15:0] ADDR_ON_OFF_TERMINAL_POLARITY = 16'h000D;
  localparam logic [15:0] ADDR_VOLTAGE_TARGET_SOURCE = 16'h0064;
  localparam logic [15:0] ADDR_CURRENT_TARGET_SOURCE = 16'h0065;
  localparam logic [15:0] ADDR_LINK_VOLTAGE_TARGET = 16'h006E;
  localparam logic [15:0] ADDR_LINK_CURRENT_TARGET = 16'h006F;
  localparam logic [15:0] ADDR_VOLTAGE_RISE_TIME = 16'h0078;
  localparam logic [15:0] ADDR_CURRENT_RISE_TIME = 16'h0079;
  localparam logic [15:0] ADDR_VOLTAGE_TRANSITION_TIME = 16'h007D;
  localparam logic [15:0] ADDR_CURRENT_TRANSITION_TIME = 16'h007E;
  localparam logic [15:0] ADDR_OVERVOLTAGE_POLICY = 16'h00C8;
  localparam logic [15:0] ADDR_OVERCURRENT_POLICY = 16'h00C9;
  localparam logic [15:0] ADDR_VSHORT_TERMINAL_FUNCTION = 16'h01F4;
  localparam logic [15:0] ADDR_ISHORT_TERMINAL_FUNCTION = 16'h01F5;
  localparam logic [15:0] ADDR_VSHORT_THRESHOLD_MODE = 16'h01FE;
  localparam logic [15:0] ADDR_ISHORT_THRESHOLD_MODE = 16'h01FF;
  localparam logic [15:0] ADDR_SHORTAGE_SIGNAL_FILTER = 16'h0208;
  localparam logic [15:0] ADDR_VSHORT_TRACKING_THRESHOLD = 16'h0212;
  localparam logic [15:0] ADDR_VSHORT_FIXED_THRESHOLD = 16'h0213;
  localparam logic [15:0] ADDR_ISHORT_TRACKING_THRESHOLD = 16'h021C;
  localparam logic [15:0] ADDR_ISHORT_FIXED_THRESHOLD = 16'h021D;
  localparam logic [15:0] ADDR_VSHORT_HYSTERESIS = 16'h0226;
  localparam logic [15:0] ADDR_ISHORT_HYSTERESIS = 16'h0227;
  localparam logic [15:0] ADDR_TERMINAL_OUTPUT_CONTROL_1 = 16'h024E;
  localparam logic [15:0] ADDR_TERMINAL_OUTPUT_CONTROL_2 = 16'h024F;
  localparam logic [15:0] ADDR_LINK_SERVER_ADDRESS = 16'h02BC;
  localparam logic [15:0] ADDR_LINK_BAUD_RATE = 16'h02BD;
  localparam logic [15:0] ADDR_LINK_PARITY_STOP = 16'h02BE;
  localparam logic [15:0] ADDR_REPLY_DELAY = 16'h02BF;
  localparam logic [15:0] ADDR_LINK_DEFAULTS_FORCE = 16'h02D0;
  localparam logic [15:0] ADDR_CHAIN_ADDRESS_ASSIGN = 16'h02D1;
  localparam logic [15:0] ADDR_SETTINGS_DEFAULT_RESTORE = 16'h0384;
  localparam logic [15:0] ADDR_LOG_POINTER_RESET = 16'h038E;
  localparam logic [15:0] ADDR_SCRATCH_AREA_1 = 16'h0320;
  localparam logic [15:0] ADDR_SCRATCH_AREA_2 = 16'h0334;
  localparam logic [15:0] SCRATCH_WORDS = 16'h000F;

  // Storage slots: single registers in table order, then both scratch areas.
  localparam int NUM_SINGLE = 36;
  localparam int NUM_SLOTS = 66;
  localparam logic [15:0] SINGLE_ADDR [0:35] = '{
    ADDR_OUTPUT_ON_OFF, ADDR_ON_OFF_SOURCE_SELECT, ADDR_ON_OFF_RESTORE_SELECT, ADDR_DEBOUNCE_STRENGTH,
    ADDR_ON_OFF_TERMINAL_POLARITY, ADDR_VOLTAGE_TARGET_SOURCE, ADDR_CURRENT_TARGET_SOURCE,
    ADDR_LINK_VOLTAGE_TARGET, ADDR_LINK_CURRENT_TARGET, ADDR_VOLTAGE_RISE_TIME, ADDR_CURRENT_RISE_TIME,
    ADDR_VOLTAGE_TRANSITION_TIME, ADDR_CURRENT_TRANSITION_TIME, ADDR_OVERVOLTAGE_POLICY,
    ADDR_OVERCURRENT_POLICY, ADDR_VSHORT_TERMINAL_FUNCTION, ADDR_ISHORT_TERMINAL_FUNCTION,
    ADDR_VSHORT_THRESHOLD_MODE, ADDR_ISHORT_THRESHOLD_MODE, ADDR_SHORTAGE_SIGNAL_FILTER,
    ADDR_VSHORT_TRACKING_THRESHOLD, ADDR_VSHORT_FIXED_THRESHOLD, ADDR_ISHORT_TRACKING_THRESHOLD,
    ADDR_ISHORT_FIXED_THRESHOLD, ADDR_VSHORT_HYSTERESIS, ADDR_ISHORT_HYSTERESIS,
    ADDR_TERMINAL_OUTPUT_CONTROL_1, ADDR_TERMINAL_OUTPUT_CONTROL_2, ADDR_LINK_SERVER_ADDRESS,
    ADDR_LINK_BAUD_RATE, ADDR_LINK_PARITY_STOP, ADDR_REPLY_DELAY, ADDR_LINK_DEFAULTS_FORCE,
    ADDR_CHAIN_ADDRESS_ASSIGN, ADDR_SETTINGS_DEFAULT_RESTORE, ADDR_LOG_POINTER_RESET};
  localparam logic [6:0] SLOT_OUTPUT_ON_OFF = 7'h00;
  localparam logic [6:0] SLOT_ON_OFF_RESTORE_SELECT = 7'h02;
  localparam logic [6:0] SLOT_VOLTAGE_TARGET_SOURCE = 7'h05;
  localparam logic [6:0] SLOT_CURRENT_TARGET_SOURCE = 7'h06;
  localparam logic [6:0] SLOT_LINK_VOLTAGE_TARGET = 7'h07;
  localparam logic [6:0] SLOT_LINK_CURRENT_TARGET = 7'h08;
  localparam logic [6:0] SLOT_OVERVOLTAGE_POLICY = 7'h0D;
  localparam logic [6:0] SLOT_OVERCURRENT_POLICY = 7'h0E;
  localparam logic [6:0] SLOT_VSHORT_TERMINAL_FUNCTION = 7'h0F;
  localparam logic [6:0] SLOT_ISHORT_TERMINAL_FUNCTION = 7'h10;
  localparam logic [6:0] SLOT_TERMINAL_OUTPUT_CONTROL_2 = 7'h1B;
  localparam logic [6:0] SLOT_LINK_SERVER_ADDRESS = 7'h1C;
  localparam logic [6:0] SLOT_LINK_BAUD_RATE = 7'h1D;
  localparam logic [6:0] SLOT_LINK_PARITY_STOP = 7'h1E;
  localparam logic [6:0] SLOT_REPLY_DELAY = 7'h1F;
  localparam logic [6:0] SLOT_LINK_DEFAULTS_FORCE = 7'h20;
  localparam logic [6:0] SLOT_CHAIN_ADDRESS_ASSIGN = 7'h21;
  localparam logic [6:0] SLOT_SETTINGS_DEFAULT_RESTORE = 7'h22;
  localparam logic [6:0] SLOT_LOG_POINTER_RESET = 7'h23;
  localparam logic [6:0] SLOT_SCRATCH_AREA_1 = 7'h24;
  localparam logic [6:0] SLOT_SCRATCH_AREA_2 = 7'h33;

  // Factory values.
  localparam logic [15:0] RST_LINK_SERVER_ADDRESS = 16'h0001;
  localparam logic [15:0] RST_LINK_BAUD_RATE = 16'h0000;
  localparam logic [15:0] RST_LINK_PARITY_STOP = 16'h0000;
  localparam logic [15:0] RST_REPLY_DELAY = 16'h0000;
  localparam logic [15:0] RST_SETTING = 16'h0000;

  // Terminal function code that hands a shortage terminal to manual control.
  localparam logic [15:0] TERM_FN_MANUAL = 16'h0002;
  localparam int TOC_VSHORT_BIT = 0;
  localparam int TOC_ISHORT_BIT = 1;
  localparam int RESTORE_BIT = 0;
  localparam int ON_BIT = 0;

endpackage

// *** shrb_host_model.sv ***
`timescale 1ns/1ps
// Host client: one word request per call, its answer sampled one cycle later.
module shrb_host_model (
  // Clock
  input wire logic clk,
  // Request towards the bank
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  output logic req_bcast,
  output logic req_rd,
  // Answer from the bank
  input wire logic rsp_valid,
  input wire logic rsp_exc,
  input wire logic [15:0] rsp_data
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    req_bcast = 1'b0;
    req_rd = 1'b0;
  end
  // Released address and data are inverted so a stale value never passes for a held request.
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic b,
                      input logic r, output logic v, output logic e, output logic [15:0] q);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    req_bcast = b;
    req_rd = r;
    @(posedge clk);
    #1;
    v = rsp_valid;
    e = rsp_exc;
    q = rsp_data;
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
  endtask
endmodule

// *** supply_holding_register_bank_tb_top.sv ***
`timescale 1ns/1ps
module supply_holding_register_bank_tb_top;
  logic clk, rstn, supply_restore, req_valid, req_bcast, req_rd, rsp_valid, rsp_exc, output_on;
  logic v, e, vss, chain_go, log_go, vsm, csm, css;
  logic [7:0] req_func;
  logic [15:0] req_addr, req_wdata, rsp_data, q, lvt, srv, vts, cts, lct, overvoltage_protection, overcurrent_protection, rdl, baud, par;
  int n_errors = 0;
  int cmp_count = 0;
  shrb_host_model i_host (.clk(clk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_bcast(req_bcast), .req_rd(req_rd), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
    .rsp_data(rsp_data));
  shrb_holding_bank i_dut (.clk(clk), .rstn(rstn), .supply_restore(supply_restore), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata), .req_bcast(req_bcast), .req_rd(req_rd),
    .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data), .output_on(output_on),
    .voltage_target_source(vts), .current_target_source(cts), .link_voltage_target(lvt), .link_current_target(lct),
    .overvoltage_policy(overvoltage_protection), .overcurrent_policy(overcurrent_protection), .reply_delay(rdl), .voltage_shortage_signal_manual(vsm),
    .voltage_shortage_signal_short(vss), .current_shortage_signal_manual(csm), .current_shortage_signal_short(css),
    .active_server_address(srv), .active_baud_rate(baud), .active_parity_stop(par), .chain_assign_start(chain_go),
    .log_pointer_reset(log_go));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic b = 1'b0,
                    input logic r = 1'b0);
    i_host.xfer(f, a, d, b, r, v, e, q);
  endtask
  task automatic pwr;
    @(posedge clk);
    #1;
    supply_restore = 1'b1;
    @(posedge clk);
    #1;
    supply_restore = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    supply_restore = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("srv_reset", srv, 16'h0001);
    for (int i = 0; i < 32; i++) begin
      rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::SINGLE_ADDR[i], 16'hA5C0 ^ 16'(i));
      rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::SINGLE_ADDR[i], 16'h0000);
      chk("word", q, 16'hA5C0 ^ 16'(i));
    end
    chk("srv_held", srv, 16'h0001);
    chk("vts", vts, 16'hA5C5);
    chk("cts", cts, 16'hA5C6);
    chk("lct", lct, 16'hA5C8);
    chk("ovp", overvoltage_protection, 16'hA5CD);
    chk("ocp", overcurrent_protection, 16'hA5CE);
    chk("rdl", rdl, 16'hA5DF);
    for (int i = 0; i < 15; i++) begin
      rq(shrb_pkg::FC_WRITE_MULTI, shrb_pkg::ADDR_SCRATCH_AREA_1 + 16'(i), 16'h1100 + 16'(i));
      rq(shrb_pkg::FC_WRITE_MULTI, shrb_pkg::ADDR_SCRATCH_AREA_2 + 16'(i), 16'h2200 + 16'(i));
      rq(shrb_pkg::FC_READ_WRITE, shrb_pkg::ADDR_SCRATCH_AREA_1 + 16'(i), 16'h0000, 1'b0, 1'b1);
      chk("pad1", q, 16'h1100 + 16'(i));
      rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_SCRATCH_AREA_2 + 16'(i), 16'h0000);
      chk("pad2", q, 16'h2200 + 16'(i));
    end
    rq(shrb_pkg::FC_READ_WRITE, shrb_pkg::ADDR_LINK_VOLTAGE_TARGET, 16'h0123);
    chk("rw_write", lvt, 16'h0123);
    chk("ack", {14'h0000, v, e}, 16'h0002);
    rq(shrb_pkg::FC_READ_HOLD, 16'h032F, 16'h0000);
    chk("unmapped", {7'h00, e, q[7:0]}, {8'h01, shrb_pkg::EXC_ADDR});
    rq(8'h04, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0000);
    chk("bad_func", {7'h00, e, q[7:0]}, {8'h01, shrb_pkg::EXC_FUNC});
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0000, 1'b1);
    chk("bcast_read", {15'h0000, v}, 16'h0000);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0001);
    chk("on", {15'h0000, output_on}, 16'h0001);
    pwr();
    chk("on_lost", {15'h0000, output_on}, 16'h0000);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_ON_OFF_RESTORE_SELECT, 16'h0001);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0001);
    pwr();
    chk("on_kept", {15'h0000, output_on}, 16'h0001);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_LINK_SERVER_ADDRESS, 16'h0005);
    rq(shrb_pkg::FC_DIAG, shrb_pkg::SUB_RESTART, 16'h1234);
    chk("diag_bad", {7'h00, e, q[7:0]}, {8'h01, shrb_pkg::EXC_DATA});
    chk("srv_wait", srv, 16'h0001);
    rq(shrb_pkg::FC_DIAG, shrb_pkg::SUB_RESTART, shrb_pkg::DIAG_DATA_ZERO);
    chk("srv_new", srv, 16'h0005);
    chk("baud", baud, 16'hA5DD);
    chk("par", par, 16'hA5DE);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_LINK_DEFAULTS_FORCE, 16'h0000);
    chk("defaults_uni", {7'h00, e, q[7:0]}, {8'h01, shrb_pkg::EXC_ADDR});
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_LINK_DEFAULTS_FORCE, 16'h0000, 1'b1);
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_LINK_SERVER_ADDRESS, 16'h0000);
    chk("defaults", q, shrb_pkg::RST_LINK_SERVER_ADDRESS);
    chk("rdl_def", rdl, shrb_pkg::RST_REPLY_DELAY);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_CHAIN_ADDRESS_ASSIGN, 16'h0001, 1'b1);
    chk("chain", {15'h0000, chain_go}, 16'h0001);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_LINK_SERVER_ADDRESS, 16'h0007);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_SETTINGS_DEFAULT_RESTORE, 16'h0001);
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_LINK_SERVER_ADDRESS, 16'h0000);
    chk("fr_link", q, 16'h0007);
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_LINK_VOLTAGE_TARGET, 16'h0000);
    chk("fr_other", q, shrb_pkg::RST_SETTING);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_LOG_POINTER_RESET, 16'h0001);
    chk("log", {15'h0000, log_go}, 16'h0001);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_VSHORT_TERMINAL_FUNCTION, shrb_pkg::TERM_FN_MANUAL);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_ISHORT_TERMINAL_FUNCTION, shrb_pkg::TERM_FN_MANUAL);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_TERMINAL_OUTPUT_CONTROL_2, 16'h0001);
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0000);
    chk("vshort", {15'h0000, vss}, 16'h0001);
    chk("pins", {12'h000, vsm, csm, vss, css}, 16'h000E);
    rq(shrb_pkg::FC_WRITE_SINGLE, shrb_pkg::ADDR_TERMINAL_OUTPUT_CONTROL_2, 16'h0002);
    rq(shrb_pkg::FC_READ_HOLD, shrb_pkg::ADDR_OUTPUT_ON_OFF, 16'h0000);
    chk("ishort", {14'h0000, vss, css}, 16'h0001);
    test_done;
  end
endmodule
